/* design/adc8c_pkg.sv */
`default_nettype none
package adc8c_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'hAA;
  localparam logic [7:0] ADDR_CFG    = 8'hAB;
  localparam logic [7:0] ADDR_RESULT = 8'hBE;

  // Control register fields
  localparam int CTRL_EN     = 7;
  localparam int CTRL_TM     = 6;
  localparam int CTRL_DONE   = 5;
  localparam int CTRL_BUSY   = 4;
  localparam int CTRL_SEL_HI = 3;
  localparam int CTRL_SEL_LO = 1;

  // Configuration register fields
  localparam int CFG_DIV_HI  = 7;
  localparam int CFG_DIV_LO  = 3;
  localparam int CFG_GAIN_HI = 1;
  localparam int CFG_GAIN_LO = 0;

  // Reset values
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [7:0] CFG_RESET    = 8'hF8;
  localparam logic [7:0] RESULT_RESET = 8'h00;

  // Start-source codes; any code with the top bit set follows the other converter
  localparam logic [2:0] SEL_SW    = 3'h0;
  localparam logic [2:0] SEL_TMR_A = 3'h1;
  localparam logic [2:0] SEL_PIN   = 3'h2;
  localparam logic [2:0] SEL_TMR_B = 3'h3;

  // Timing in SAR clocks
  localparam logic [1:0] TRACK_SAR_CLKS = 2'h3;
  localparam logic [3:0] CONV_SAR_CLKS  = 4'h8;

  // Successive approximation seed: mid-scale trial
  localparam logic [7:0] SAR_MSB = 8'h80;

  // Converter sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_TRACK = 3'b010,
    ST_CONV  = 3'b100
  } adc8c_state_type;

endpackage
`default_nettype wire

/* design/adc8c_pin_sync.sv */
`default_nettype none
module adc8c_pin_sync (
  input  wire logic clk_sys_i,
  input  wire logic rstn_i,
  input  wire logic pin_i,
  output logic      level_o
);

  typedef struct packed {
    logic [2:0] ff;
    logic       level;
  } adc8c_sync_type;

  adc8c_sync_type sync_reg;
  adc8c_sync_type sync_next;

  // ----------------------------------------------------------------
  // Three-stage chain; the level moves only when stages two and three agree
  // ----------------------------------------------------------------
  always_comb
  begin
    sync_next    = sync_reg;
    sync_next.ff = {sync_reg.ff[1:0], pin_i};
    if (sync_reg.ff[1] == sync_reg.ff[2])
    begin
      sync_next.level = sync_reg.ff[2];
    end
  end

  // State register
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sync_reg <= '0;
    end
    else
    begin
      sync_reg <= sync_next;
    end
  end

  assign level_o = sync_reg.level;

endmodule
`default_nettype wire

/* design/adc8c_sar_core.sv */
`default_nettype none
module adc8c_sar_core (
  input  wire logic       clk_sys_i,
  input  wire logic       rstn_i,
  input  wire logic       start_i,
  input  wire logic       step_i,
  input  wire logic       cmp_i,
  output logic      [7:0] trial_o,
  output logic      [7:0] result_o,
  output logic            done_o
);

  typedef struct packed {
    logic [7:0] trial;
    logic [7:0] mask;
    logic [3:0] steps;
    logic [7:0] result;
    logic       done;
  } adc8c_sar_type;

  adc8c_sar_type sar_reg;
  adc8c_sar_type sar_next;
  logic [7:0]    kept;

  // ----------------------------------------------------------------
  // One bit decided per SAR clock, MSB first; a full-scale input keeps
  // every bit, so the code saturates at all ones by construction
  // ----------------------------------------------------------------
  always_comb
  begin
    sar_next      = sar_reg;
    sar_next.done = 1'b0;
    kept          = cmp_i ? sar_reg.trial : (sar_reg.trial & ~sar_reg.mask);
    if (start_i)
    begin
      sar_next.trial = adc8c_pkg::SAR_MSB;
      sar_next.mask  = adc8c_pkg::SAR_MSB;
      sar_next.steps = 4'h0;
    end
    else if (step_i && (sar_reg.steps < adc8c_pkg::CONV_SAR_CLKS))
    begin
      sar_next.trial = kept | (sar_reg.mask >> 1);
      sar_next.mask  = sar_reg.mask >> 1;
      sar_next.steps = sar_reg.steps + 4'h1;
      if (sar_reg.steps == adc8c_pkg::CONV_SAR_CLKS - 4'h1)
      begin
        sar_next.result = kept;
        sar_next.done   = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sar_reg <= '0;
    end
    else
    begin
      sar_reg <= sar_next;
    end
  end

  assign trial_o  = sar_reg.trial;
  assign result_o = sar_reg.result;
  assign done_o   = sar_reg.done;

endmodule
`default_nettype wire

/* design/adc8c_conv_ctrl.sv */
// Behaviour
// - Enable bit off means shutdown, on accepts starts
// - Normal mode tracks except during conversion
// - Done flag sticky, cleared only by writing 0
// - Busy during conversion; done set on busy fall (not when clearing enable aborts, which leaves done unchanged)
// - Busy write 0 ignored; 1 starts if software code
// - Start-source field picks the start trigger
// - Low-power mode tracks 3 SAR clocks, then converts
// - Low-power pin mode tracks while pin low
// - Control bit 0 reads 0, writes ignored
// - Result is saturating 8-bit proportional code
// - Conversion lasts 8 SAR clocks
// - SAR clock ratio equals divider setting plus one
// - Busy fall raises interrupt request when enabled
//
// The plain strobed port was decided locally.
`default_nettype none
module adc8c_conv_ctrl (
  input  wire logic       clk_sys_i,
  input  wire logic       rstn_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic       timer_a_ovf_i,
  input  wire logic       timer_b_ovf_i,
  input  wire logic       other_adc_start_i,
  input  wire logic       ext_convert_start_i,
  input  wire logic       cmp_i,
  input  wire logic       irq_enable_i,
  output logic            conv_enable_o,
  output logic            track_o,
  output logic            conv_busy_o,
  output logic      [7:0] sar_trial_o,
  output logic      [1:0] pga_gain_o,
  output logic            conv_irq_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    adc8c_pkg::adc8c_state_type state;
    logic                       en;
    logic                       tm;
    logic                       done;
    logic                       busy;
    logic [2:0]                 sel;
    logic [4:0]                 div;
    logic [1:0]                 gain;
    logic [4:0]                 div_cnt;
    logic [1:0]                 trk_cnt;
    logic                       pin_prev;
    logic                       track;
    logic                       irq;
    logic [7:0]                 result;
    logic [7:0]                 rdata;
  } adc8c_ctrl_type;

  adc8c_ctrl_type ctrl_reg;
  adc8c_ctrl_type ctrl_next;

  logic       pin_level;
  logic       core_start;
  logic       core_step;
  logic       core_done;
  logic [7:0] core_result;
  logic [7:0] core_trial;
  logic       sar_tick;
  logic       ctrl_wr;
  logic       sw_start;
  logic       pin_rise;
  logic       trig;
  logic       busy_fall;

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  // The start pin is asynchronous to the system clock
  adc8c_pin_sync u_pin_sync (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .pin_i     (ext_convert_start_i),
    .level_o   (pin_level)
  );

  // Bit decisions; the comparator is clocked by the analog core on our clock
  adc8c_sar_core u_sar_core (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .start_i   (core_start),
    .step_i    (core_step),
    .cmp_i     (cmp_i),
    .trial_o   (core_trial),
    .result_o  (core_result),
    .done_o    (core_done)
  );

  // Reads the control word as software sees it
  function automatic logic [7:0] ctrl_word(input adc8c_ctrl_type c);
    ctrl_word = {c.en, c.tm, c.done, c.busy, c.sel, 1'b0};
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    ctrl_next       = ctrl_reg;
    ctrl_next.irq   = 1'b0;
    ctrl_next.rdata = 8'h00;
    core_start      = 1'b0;
    busy_fall       = 1'b0;
    ctrl_wr         = reg_wr_i && (reg_addr_i == adc8c_pkg::ADDR_CTRL);
    pin_rise        = pin_level && !ctrl_reg.pin_prev;
    ctrl_next.pin_prev = pin_level;

    // SAR clock tick: ratio to system clock is divider plus one
    sar_tick          = (ctrl_reg.div_cnt == ctrl_reg.div);
    ctrl_next.div_cnt = sar_tick ? 5'h00 : ctrl_reg.div_cnt + 5'h01;

    // Register writes; busy is not stored by software
    if (ctrl_wr)
    begin
      ctrl_next.en  = reg_wdata_i[adc8c_pkg::CTRL_EN];
      ctrl_next.tm  = reg_wdata_i[adc8c_pkg::CTRL_TM];
      ctrl_next.sel = reg_wdata_i[adc8c_pkg::CTRL_SEL_HI:adc8c_pkg::CTRL_SEL_LO];
      if (!reg_wdata_i[adc8c_pkg::CTRL_DONE])
      begin
        ctrl_next.done = 1'b0;
      end
    end
    if (reg_wr_i && (reg_addr_i == adc8c_pkg::ADDR_CFG))
    begin
      ctrl_next.div  = reg_wdata_i[adc8c_pkg::CFG_DIV_HI:adc8c_pkg::CFG_DIV_LO];
      ctrl_next.gain = reg_wdata_i[adc8c_pkg::CFG_GAIN_HI:adc8c_pkg::CFG_GAIN_LO];
    end

    // Software start uses the code being written, so one write can select and start
    sw_start = ctrl_wr && reg_wdata_i[adc8c_pkg::CTRL_BUSY];

    // Trigger selection
    case (ctrl_next.sel)
      adc8c_pkg::SEL_SW:    trig = sw_start;
      adc8c_pkg::SEL_TMR_A: trig = timer_a_ovf_i;
      adc8c_pkg::SEL_PIN:   trig = pin_rise;
      adc8c_pkg::SEL_TMR_B: trig = timer_b_ovf_i;
      default:              trig = other_adc_start_i;
    endcase

    // Sequencer
    case (ctrl_reg.state)
      adc8c_pkg::ST_IDLE:
      begin
        if (trig && ctrl_next.en)
        begin
          ctrl_next.div_cnt = 5'h00;
          ctrl_next.busy    = 1'b1;
          if (ctrl_next.tm && (ctrl_next.sel != adc8c_pkg::SEL_PIN))
          begin
            ctrl_next.state   = adc8c_pkg::ST_TRACK;
            ctrl_next.trk_cnt = 2'h0;
          end
          else
          begin
            // Pin mode in low power has tracked while the pin was low
            ctrl_next.state = adc8c_pkg::ST_CONV;
            core_start      = 1'b1;
          end
        end
      end
      adc8c_pkg::ST_TRACK:
      begin
        // New triggers fall through unheard here
        if (sar_tick)
        begin
          ctrl_next.trk_cnt = ctrl_reg.trk_cnt + 2'h1;
          if (ctrl_reg.trk_cnt == adc8c_pkg::TRACK_SAR_CLKS - 2'h1)
          begin
            ctrl_next.state   = adc8c_pkg::ST_CONV;
            ctrl_next.div_cnt = 5'h00;
            core_start        = 1'b1;
          end
        end
      end
      adc8c_pkg::ST_CONV:
      begin
        if (core_done)
        begin
          ctrl_next.result = core_result;
          ctrl_next.busy   = 1'b0;
          ctrl_next.state  = adc8c_pkg::ST_IDLE;
          busy_fall        = 1'b1;
        end
      end
      default:
      begin
        ctrl_next.state = adc8c_pkg::ST_IDLE;
        ctrl_next.busy  = 1'b0;
      end
    endcase

    // Disabling aborts any sequence without reporting completion
    if (!ctrl_next.en)
    begin
      ctrl_next.state = adc8c_pkg::ST_IDLE;
      ctrl_next.busy  = 1'b0;
      busy_fall       = 1'b0;
    end

    // Completion: set after the write so a same-cycle clear loses
    if (busy_fall)
    begin
      ctrl_next.done = 1'b1;
      ctrl_next.irq  = irq_enable_i;
    end

    // Tracking switch for the analog core
    if (!ctrl_next.en)
    begin
      ctrl_next.track = 1'b0;
    end
    else if (!ctrl_next.tm)
    begin
      ctrl_next.track = (ctrl_next.state != adc8c_pkg::ST_CONV);
    end
    else if (ctrl_next.sel == adc8c_pkg::SEL_PIN)
    begin
      ctrl_next.track = (ctrl_next.state == adc8c_pkg::ST_IDLE) && !ctrl_next.pin_prev;
    end
    else
    begin
      ctrl_next.track = (ctrl_next.state == adc8c_pkg::ST_TRACK);
    end

    // Read data stand for the one cycle after the strobe; unmapped reads give zero
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        adc8c_pkg::ADDR_CTRL:   ctrl_next.rdata = ctrl_word(ctrl_reg);
        adc8c_pkg::ADDR_CFG:    ctrl_next.rdata = {ctrl_reg.div, 1'b0, ctrl_reg.gain};
        adc8c_pkg::ADDR_RESULT: ctrl_next.rdata = ctrl_reg.result;
        default:                ctrl_next.rdata = 8'h00;
      endcase
    end
  end

  // Core steps only on SAR ticks inside a conversion
  assign core_step = sar_tick && (ctrl_reg.state == adc8c_pkg::ST_CONV);

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ctrl_reg        <= '0;
      ctrl_reg.state  <= adc8c_pkg::ST_IDLE;
      ctrl_reg.en     <= adc8c_pkg::CTRL_RESET[adc8c_pkg::CTRL_EN];
      ctrl_reg.tm     <= adc8c_pkg::CTRL_RESET[adc8c_pkg::CTRL_TM];
      ctrl_reg.sel    <= adc8c_pkg::CTRL_RESET[adc8c_pkg::CTRL_SEL_HI:adc8c_pkg::CTRL_SEL_LO];
      ctrl_reg.div    <= adc8c_pkg::CFG_RESET[adc8c_pkg::CFG_DIV_HI:adc8c_pkg::CFG_DIV_LO];
      ctrl_reg.gain   <= adc8c_pkg::CFG_RESET[adc8c_pkg::CFG_GAIN_HI:adc8c_pkg::CFG_GAIN_LO];
      ctrl_reg.result <= adc8c_pkg::RESULT_RESET;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata_o   = ctrl_reg.rdata;
  assign conv_enable_o = ctrl_reg.en;
  assign track_o       = ctrl_reg.track;
  assign conv_busy_o   = ctrl_reg.busy;
  assign sar_trial_o   = core_trial;
  assign pga_gain_o    = ctrl_reg.gain;
  assign conv_irq_o    = ctrl_reg.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Cycle counters used only by the checks below
  logic [7:0] trk_cyc_reg;
  logic [8:0] conv_cyc_reg;

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      trk_cyc_reg  <= 8'h00;
      conv_cyc_reg <= 9'h000;
    end
    else
    begin
      trk_cyc_reg  <= (ctrl_next.state == adc8c_pkg::ST_TRACK && ctrl_reg.state == adc8c_pkg::ST_TRACK)
                      ? trk_cyc_reg + 8'h01 : 8'h00;
      conv_cyc_reg <= (ctrl_next.state == adc8c_pkg::ST_CONV && ctrl_reg.state == adc8c_pkg::ST_CONV)
                      ? conv_cyc_reg + 9'h001 : 9'h000;
    end
  end

  default clocking chk_clk @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);

  chk_off_no_busy: assert property (!ctrl_reg.en |-> !conv_busy_o && !track_o)
    else $error("busy or tracking while disabled");
  chk_normal_track: assert property (ctrl_reg.en && !ctrl_reg.tm && ctrl_reg.state != adc8c_pkg::ST_CONV |-> track_o)
    else $error("normal mode not tracking outside conversion");
  chk_done_sticky: assert property (ctrl_reg.done && !(ctrl_wr && !reg_wdata_i[adc8c_pkg::CTRL_DONE]) |=> ctrl_reg.done)
    else $error("done flag dropped without software clear");
  chk_busy_fall_done: assert property ($fell(conv_busy_o) && ctrl_reg.en |-> ctrl_reg.done)
    else $error("busy fell without setting done");
  chk_busy_wr_zero: assert property (ctrl_wr && !reg_wdata_i[adc8c_pkg::CTRL_BUSY] && ctrl_reg.state == adc8c_pkg::ST_IDLE
      && reg_wdata_i[adc8c_pkg::CTRL_SEL_HI:adc8c_pkg::CTRL_SEL_LO] == adc8c_pkg::SEL_SW |=> !conv_busy_o)
    else $error("writing busy zero started a conversion");
  chk_sw_start: assert property (ctrl_wr && reg_wdata_i == 8'h90 && ctrl_reg.state == adc8c_pkg::ST_IDLE
      |=> conv_busy_o && ctrl_reg.state == adc8c_pkg::ST_CONV)
    else $error("software start did not begin a conversion");
  chk_track_len: assert property (ctrl_reg.state == adc8c_pkg::ST_TRACK && ctrl_next.state == adc8c_pkg::ST_CONV
      |-> trk_cyc_reg == 8'(3 * (ctrl_reg.div + 6'h01) - 1))
    else $error("low-power tracking period is not three SAR clocks");
  chk_pin_track: assert property (ctrl_reg.en && ctrl_reg.tm && ctrl_reg.sel == adc8c_pkg::SEL_PIN
      && ctrl_reg.state == adc8c_pkg::ST_IDLE |-> track_o == !ctrl_reg.pin_prev)
    else $error("pin mode tracking does not follow the pin");
  chk_bit0_zero: assert property (reg_rd_i && reg_addr_i == adc8c_pkg::ADDR_CTRL |=> reg_rdata_o[0] == 1'b0)
    else $error("unused control bit read as one");
  chk_conv_len: assert property (ctrl_reg.state == adc8c_pkg::ST_CONV && core_done && ctrl_next.en
      |-> conv_cyc_reg == 9'(8 * (ctrl_reg.div + 6'h01)))
    else $error("conversion length is not eight SAR clocks");
  chk_irq_on_fall: assert property ($fell(conv_busy_o) && ctrl_reg.en && $past(irq_enable_i) |-> conv_irq_o)
    else $error("no interrupt request on busy fall");
  chk_no_retrigger: assert property (ctrl_reg.state == adc8c_pkg::ST_CONV && !core_done && ctrl_next.en
      |=> ctrl_reg.state == adc8c_pkg::ST_CONV)
    else $error("running conversion disturbed");

  cov_sw_conv: cover property (ctrl_reg.sel == adc8c_pkg::SEL_SW && $fell(conv_busy_o) && ctrl_reg.done);
  cov_lp_track: cover property (ctrl_reg.state == adc8c_pkg::ST_TRACK ##1 ctrl_reg.state == adc8c_pkg::ST_CONV);
  cov_pin_start: cover property (ctrl_reg.sel == adc8c_pkg::SEL_PIN && $rose(conv_busy_o));
  cov_full_scale: cover property ($fell(conv_busy_o) && ctrl_reg.result == 8'hFF);

endmodule
`default_nettype wire

/* sim/adc8c_analog_model.sv */
`default_nettype none
module adc8c_analog_model (
  input  wire logic       clk_sys_i,
  input  wire logic [8:0] vin_i,
  input  wire logic       track_i,
  input  wire logic [7:0] trial_i,
  output logic            cmp_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [8:0] held_reg;

  // Hold node follows the input only while the switch is closed
  always_ff @(posedge clk_sys_i)
  begin
    if (track_i)
      held_reg <= vin_i;
  end

  // Codes above 255 pass every trial, so the result saturates
  assign cmp_o = ({1'b0, trial_i} <= held_reg);
endmodule
`default_nettype wire

/* sim/tb_adc8c_conv_ctrl.sv */
`default_nettype none
module tb_adc8c_conv_ctrl;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk_sys_i, rstn_i, reg_wr_i, reg_rd_i, rd_pend;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, sar_trial_o;
  logic       timer_a_ovf_i, timer_b_ovf_i, other_adc_start_i, ext_convert_start_i;
  logic       cmp_i, irq_enable_i, conv_enable_o, track_o, conv_busy_o, conv_irq_o;
  logic [1:0] pga_gain_o;
  logic [8:0] vin_i;
  logic [7:0] rd_q[$];
  int         len_q[$];
  logic       irq_q[$];
  int         error_cnt, checked, busy_len, p_cur;

  adc8c_conv_ctrl u_adc8c_conv_ctrl (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .timer_a_ovf_i(timer_a_ovf_i),
    .timer_b_ovf_i(timer_b_ovf_i), .other_adc_start_i(other_adc_start_i),
    .ext_convert_start_i(ext_convert_start_i), .cmp_i(cmp_i),
    .irq_enable_i(irq_enable_i), .conv_enable_o(conv_enable_o), .track_o(track_o),
    .conv_busy_o(conv_busy_o), .sar_trial_o(sar_trial_o), .pga_gain_o(pga_gain_o),
    .conv_irq_o(conv_irq_o));

  adc8c_analog_model u_adc8c_analog_model (.clk_sys_i(clk_sys_i), .vin_i(vin_i),
    .track_i(track_o), .trial_i(sar_trial_o), .cmp_o(cmp_i));

  // ----------------------------------------
  // Clock, checking and closing
  // ----------------------------------------
  initial
  begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("Errors %0d, checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge clk_sys_i)
    rd_pend <= reg_rd_i;

  // Watcher: pops notes as read data and busy falls appear
  always @(negedge clk_sys_i)
  begin
    if (rd_pend === 1'b1)
      check(reg_rdata_o, rd_q.pop_front());
    if (conv_busy_o === 1'b1)
      busy_len++;
    else if (busy_len > 0)
    begin
      if (len_q[0] >= 0)
        check(8'(busy_len), 8'(len_q[0]));
      check({7'h00, conv_irq_o}, {7'h00, irq_q.pop_front()});
      void'(len_q.pop_front());
      busy_len = 0;
    end
  end

  // ----------------------------------------
  // Bus and trigger tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    rd_q.push_back(exp);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  // Pin gets a low phase longer than the synchroniser, then rises
  task automatic fire(input logic tm, input logic [2:0] s);
    if (s == adc8c_pkg::SEL_SW)
      wr(adc8c_pkg::ADDR_CTRL, {1'b1, tm, 6'h30});
    else if (s == adc8c_pkg::SEL_PIN)
    begin
      @(posedge clk_sys_i);
      ext_convert_start_i <= 1'b0;
      repeat (5) @(posedge clk_sys_i);
      ext_convert_start_i <= 1'b1;
    end
    else
    begin
      @(posedge clk_sys_i);
      timer_a_ovf_i <= (s == adc8c_pkg::SEL_TMR_A);
      timer_b_ovf_i <= (s == adc8c_pkg::SEL_TMR_B);
      other_adc_start_i <= s[2];
      @(posedge clk_sys_i);
      timer_a_ovf_i <= 1'b0;
      timer_b_ovf_i <= 1'b0;
      other_adc_start_i <= 1'b0;
    end
  endtask

  task automatic wait_busy(input logic [7:0] exp);
    int n;
    n = 0;
    while (conv_busy_o !== 1'b1 && n < 10)
    begin
      @(negedge clk_sys_i);
      n++;
    end
    check({7'h00, conv_busy_o}, exp);
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    while (conv_busy_o !== 1'b0 && n < 1000)
    begin
      @(negedge clk_sys_i);
      n++;
    end
    check({7'h00, conv_busy_o}, 8'h00);
  endtask

  // One conversion; a second trigger while busy must change nothing
  task automatic run(input logic tm, input logic [2:0] s, input logic [8:0] v);
    logic ie;
    ie = 1'($urandom_range(0, 1));
    @(posedge clk_sys_i);
    vin_i <= v;
    irq_enable_i <= ie;
    wr(adc8c_pkg::ADDR_CTRL, {1'b1, tm, 2'b00, s, 1'b0});
    repeat (6) @(posedge clk_sys_i);
    // Settled idle levels: powered, and tracking only in normal mode
    @(negedge clk_sys_i);
    check({7'h00, conv_enable_o}, 8'h01);
    check({7'h00, track_o}, {7'h00, !tm});
    len_q.push_back((tm && s != adc8c_pkg::SEL_PIN) ? 11 * p_cur + 1 : 8 * p_cur + 1);
    irq_q.push_back(ie);
    fire(tm, s);
    wait_busy(8'h01);
    fire(tm, s);
    wait_idle();
    rd(adc8c_pkg::ADDR_CTRL, {1'b1, tm, 2'b10, s, 1'b0});
    rd(adc8c_pkg::ADDR_RESULT, (v > 9'd255) ? 8'hFF : v[7:0]);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {rstn_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
    {timer_a_ovf_i, timer_b_ovf_i, other_adc_start_i, ext_convert_start_i} = '0;
    irq_enable_i = 1'b0;
    vin_i = 9'h000;
    {error_cnt, checked, busy_len} = '0;
    p_cur = 32;
    void'($urandom(32'hCFEBC6A5));
    repeat (12) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    rd(adc8c_pkg::ADDR_CTRL, 8'h00);
    rd(8'hAB, 8'hF8);
    rd(adc8c_pkg::ADDR_RESULT, 8'h00);
    rd(8'h55, 8'h00);
    wr(adc8c_pkg::ADDR_CTRL, 8'h81);
    rd(adc8c_pkg::ADDR_CTRL, 8'h80);
    wr(adc8c_pkg::ADDR_CTRL, 8'h92);
    rd(adc8c_pkg::ADDR_CTRL, 8'h82);
    // Divider 1 gives two system cycles per SAR clock
    wr(8'hAB, 8'h0F);
    p_cur = 2;
    rd(8'hAB, 8'h0B);
    check({6'h00, pga_gain_o}, 8'h03);
    for (int t = 0; t < 2; t++)
      for (int s = 0; s < 8; s++)
        run(t[0], s[2:0], 9'($urandom_range(0, 255)));
    wr(adc8c_pkg::ADDR_CTRL, 8'hA0);
    rd(adc8c_pkg::ADDR_CTRL, 8'hA0);
    wr(adc8c_pkg::ADDR_CTRL, 8'h80);
    rd(adc8c_pkg::ADDR_CTRL, 8'h80);
    wr(8'hAB, 8'h00);
    p_cur = 1;
    run(1'b0, 3'h0, 9'd300);
    run(1'b0, 3'h0, 9'd128);
    wr(adc8c_pkg::ADDR_RESULT, 8'h11);
    rd(adc8c_pkg::ADDR_RESULT, 8'h80);
    // Disabled converter ignores a timer A trigger and a software start
    wr(adc8c_pkg::ADDR_CTRL, 8'h02);
    fire(1'b0, 3'h1);
    wait_busy(8'h00);
    check({7'h00, track_o}, 8'h00);
    check({7'h00, conv_enable_o}, 8'h00);
    wr(adc8c_pkg::ADDR_CTRL, 8'h10);
    rd(adc8c_pkg::ADDR_CTRL, 8'h00);
    // Clearing enable mid-conversion aborts without done
    wr(8'hAB, 8'h18);
    irq_enable_i <= 1'b1;
    len_q.push_back(-1);
    irq_q.push_back(1'b0);
    wr(adc8c_pkg::ADDR_CTRL, 8'h90);
    repeat (10) @(posedge clk_sys_i);
    wr(adc8c_pkg::ADDR_CTRL, 8'h00);
    wait_idle();
    rd(adc8c_pkg::ADDR_CTRL, 8'h00);
    rd(adc8c_pkg::ADDR_RESULT, 8'h80);
    complete_run();
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    #800000;
    error_cnt++;
    complete_run();
  end
endmodule
`default_nettype wire
